// File: iex_cpu_model.sv
// Purpose: Processor model that acknowledges an active group line and times the vector.
// Assumes: One fetch at a time, asked for by the bench through take.
// Notes:   Waits delay cycles before acknowledging, to act as a slow core.
`timescale 1ns/1ns
module iex_cpu_model
  import iex_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        take,
  input  wire logic [3:0]  delay,
  input  wire logic [11:0] lines,
  input  wire iex_vec_t    vec_in,
  output logic             cpu_ack,
  output logic             done,
  output logic [6:0]       got_src,
  output logic [31:0]      got_vec,
  output logic [7:0]       lat
);
  int n;

  initial
  begin
    {cpu_ack, done, got_src, got_vec, lat} = '0;
    forever
    begin
      @(posedge ref_clk);
      if (take !== 1'b1)
        done <= 1'b0;
      else if (done !== 1'b1 && (|lines))
      begin
        repeat (delay) @(posedge ref_clk);
        cpu_ack <= 1'b1;
        @(posedge ref_clk);
        cpu_ack <= 1'b0;
        n = 0;
        do
        begin
          @(posedge ref_clk);
          n++;
        end
        while (vec_in.valid !== 1'b1 && n < 40);
        got_src <= vec_in.src;
        got_vec <= vec_in.vector;
        lat     <= n[7:0];
        done    <= 1'b1;
      end
    end
  end
endmodule

// File: iex_expander.sv
// Purpose: Interrupt expander with per-source enable, vector table and
//          external interrupt inputs, reached over APB.
// Assumes: All inputs synchronous to ref_clk; APB answers with one wait.
// Notes:   The rules that this block keeps follow.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module iex_expander
  import iex_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire iex_apb_req_t apb_req,
  output iex_apb_rsp_t      apb_rsp,
  input  wire logic [95:0]  periph_irq,
  input  wire logic         timer0_irq,
  input  wire logic         timer1_irq,
  input  wire logic         timer2_irq,
  input  wire logic         ext_irq_first,
  input  wire logic         ext_irq_second,
  input  wire logic         shared_nmi_irq_pin,
  input  wire logic         cpu_ack,
  output logic [11:0]       cpu_group_irq_lines,
  output logic              cpu_irq_line_thirteen,
  output logic              cpu_irq_line_fourteen,
  output logic              cpu_nmi,
  output logic [3:0]        cpu_top_line,
  output iex_vec_t          vec_out
);
  typedef enum logic [0:0] {st_idle, st_fetch} iex_state_t;

  logic [31:0]        ctrl;
  logic [31:0]        extcfg;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] src_q;
  logic [31:0]        vec_ram [NUM_SRC];
  logic [31:0]        next_ctrl;
  logic [31:0]        next_extcfg;
  logic [NUM_SRC-1:0] next_enable;
  logic [NUM_SRC-1:0] next_pending;
  logic [NUM_SRC-1:0] raw_src;
  logic [NUM_SRC-1:0] set_pend;
  logic [NUM_SRC-1:0] clr_pend;
  logic [NUM_GRP-1:0] grp_act;
  logic [NUM_GRP-1:0] next_lines;
  logic [3:0]         next_top;
  logic               next_l13;
  logic               next_l14;
  logic               next_nmi;
  iex_apb_rsp_t       next_rsp;
  logic               wr_fire;
  logic [9:0]         word;
  logic               vec_we;
  logic [6:0]         vec_idx;

  iex_state_t         state;
  iex_state_t         next_state;
  logic [3:0]         fetch_line;
  logic [3:0]         next_line;
  logic [6:0]         fetch_src;
  logic [6:0]         next_src;
  logic [2:0]         fetch_cnt;
  logic [2:0]         next_cnt;
  iex_vec_t           next_vec;
  logic               fetch_start;
  logic               fetch_done;

  logic [NUM_EXT-1:0] ext_pin;
  logic [NUM_EXT-1:0] ext_evt;
  logic [CNT_W-1:0]   ext_stamp [NUM_EXT];

  assign ext_pin = {shared_nmi_irq_pin, shared_nmi_irq_pin,
                    ext_irq_second, ext_irq_first};

  genvar e;
  generate
    for (e = 0; e < NUM_EXT; e++)
    begin : g_ext
      iex_ext_chan #(
        .HAS_CNT (e != EXT_NMI)
      ) u_chan (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .pin         (ext_pin[e]),
        .enable      (extcfg[e*EXT_STRIDE+EXT_EN_BIT]),
        .rising      (extcfg[e*EXT_STRIDE+EXT_POL_BIT]),
        .event_pulse (ext_evt[e]),
        .stamp       (ext_stamp[e])
      );
    end
  endgenerate

  function automatic logic [3:0] low_line(input logic [NUM_GRP-1:0] act);
    logic [3:0] r;
    r = 4'hf;
    for (int i = NUM_GRP - 1; i >= 0; i--)
      if (act[i])
        r = 4'(i);
    return r;
  endfunction

  function automatic logic [2:0] low_bit(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction

  // Sources, pending flags and line outputs.
  always_comb
  begin
    raw_src = periph_irq;
    raw_src[SRC_TIMER0] = periph_irq[SRC_TIMER0] | timer0_irq;
    raw_src[SRC_EXT1] = periph_irq[SRC_EXT1] | ext_evt[EXT_FIRST];
    raw_src[SRC_EXT2] = periph_irq[SRC_EXT2] | ext_evt[EXT_SECOND];
    for (int i = 0; i < NUM_SRC; i++)
      if (i >= USED_SRC)
        raw_src[i] = 1'b0;
    set_pend = raw_src & ~src_q;
    clr_pend = '0;
    if (wr_fire && word >= W_PEND0 && word < W_PEND0 + 10'(NUM_GRP))
      clr_pend[(word - W_PEND0)*GRP_SIZE +: GRP_SIZE] = apb_req.pwdata[7:0];
    if (fetch_done)
      clr_pend[fetch_src] = 1'b1;
    next_pending = (pending & ~clr_pend) | set_pend;
    for (int g = 0; g < NUM_GRP; g++)
      grp_act[g] = |(pending[g*GRP_SIZE +: GRP_SIZE]
                     & enable[g*GRP_SIZE +: GRP_SIZE]);
    next_lines = grp_act;
    next_top = low_line(grp_act);
    next_l13 = ext_evt[EXT_THIRTEEN]
             | (timer1_irq & ctrl[CTRL_T1_ROUTE]);
    next_l14 = timer2_irq;
    next_nmi = ext_evt[EXT_NMI];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pending               <= '0;
      src_q                 <= '0;
      cpu_group_irq_lines   <= '0;
      cpu_top_line          <= 4'hf;
      cpu_irq_line_thirteen <= 1'b0;
      cpu_irq_line_fourteen <= 1'b0;
      cpu_nmi               <= 1'b0;
    end
    else
    begin
      pending               <= next_pending;
      src_q                 <= raw_src;
      cpu_group_irq_lines   <= next_lines;
      cpu_top_line          <= next_top;
      cpu_irq_line_thirteen <= next_l13;
      cpu_irq_line_fourteen <= next_l14;
      cpu_nmi               <= next_nmi;
    end
  end

  // Vector fetch on processor acknowledge.
  always_comb
  begin
    next_state  = state;
    next_line   = fetch_line;
    next_src    = fetch_src;
    next_cnt    = fetch_cnt;
    next_vec    = vec_out;
    next_vec.valid = 1'b0;
    fetch_start = (state == st_idle) && cpu_ack && (|grp_act);
    fetch_done  = (state == st_fetch) && (fetch_cnt == 3'(FETCH_CYC - 2));
    case (state)
      st_idle:
      begin
        if (fetch_start)
        begin
          next_line  = low_line(grp_act);
          next_src   = 7'(low_line(grp_act) * GRP_SIZE)
                     + 7'(low_bit(pending[low_line(grp_act)*GRP_SIZE +: GRP_SIZE]
                       & enable[low_line(grp_act)*GRP_SIZE +: GRP_SIZE]));
          next_cnt   = 3'h0;
          next_state = st_fetch;
        end
      end
      st_fetch:
      begin
        next_cnt = fetch_cnt + 3'h1;
        if (fetch_done)
        begin
          next_vec.valid  = 1'b1;
          next_vec.src    = fetch_src;
          next_vec.vector = vec_ram[fetch_src];
          next_state      = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state      <= st_idle;
      fetch_line <= 4'h0;
      fetch_src  <= 7'h00;
      fetch_cnt  <= 3'h0;
      vec_out    <= '0;
    end
    else
    begin
      state      <= next_state;
      fetch_line <= next_line;
      fetch_src  <= next_src;
      fetch_cnt  <= next_cnt;
      vec_out    <= next_vec;
    end
  end

  // APB slave with one wait cycle.
  always_comb
  begin
    word        = apb_req.paddr[11:2];
    wr_fire     = apb_req.psel & apb_req.penable & apb_rsp.pready
                & apb_req.pwrite & ~apb_rsp.pslverr;
    next_ctrl   = ctrl;
    next_extcfg = extcfg;
    next_enable = enable;
    vec_we      = 1'b0;
    vec_idx     = 7'(word - W_VEC0);
    next_rsp    = '0;
    if (apb_req.psel && apb_req.penable && !apb_rsp.pready)
    begin
      next_rsp.pready = 1'b1;
      if (word == W_CTRL)
        next_rsp.prdata = ctrl;
      else if (word == W_EXTCFG)
        next_rsp.prdata = extcfg;
      else if (word == W_STAT)
        next_rsp.prdata = {16'h0000, 1'b0, state == st_fetch,
                           cpu_irq_line_fourteen, cpu_irq_line_thirteen,
                           cpu_group_irq_lines};
      else if (word >= W_EN0 && word < W_EN0 + 10'(NUM_GRP))
        next_rsp.prdata = {24'h000000, enable[(word - W_EN0)*GRP_SIZE +: GRP_SIZE]};
      else if (word >= W_PEND0 && word < W_PEND0 + 10'(NUM_GRP))
        next_rsp.prdata = {24'h000000, pending[(word - W_PEND0)*GRP_SIZE +: GRP_SIZE]};
      else if (word >= W_CNT0 && word < W_CNT0 + 10'(EXT_THIRTEEN + 1))
        next_rsp.prdata = {16'h0000, ext_stamp[2'(word - W_CNT0)]};
      else if (word >= W_VEC0 && word < W_VEC0 + 10'(NUM_SRC))
        next_rsp.prdata = vec_ram[vec_idx];
      else
        next_rsp.pslverr = 1'b1;
    end
    if (wr_fire)
    begin
      if (word == W_CTRL)
        next_ctrl = apb_req.pwdata;
      else if (word == W_EXTCFG)
        next_extcfg = apb_req.pwdata;
      else if (word >= W_EN0 && word < W_EN0 + 10'(NUM_GRP))
        next_enable[(word - W_EN0)*GRP_SIZE +: GRP_SIZE] = apb_req.pwdata[7:0];
      else if (word >= W_VEC0 && word < W_VEC0 + 10'(NUM_SRC))
        vec_we = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl    <= CTRL_RST;
      extcfg  <= EXTCFG_RST;
      enable  <= '0;
      apb_rsp <= '0;
      for (int i = 0; i < NUM_SRC; i++)
        vec_ram[i] <= 32'h0000_0000;
    end
    else
    begin
      ctrl    <= next_ctrl;
      extcfg  <= next_extcfg;
      enable  <= next_enable;
      apb_rsp <= next_rsp;
      if (vec_we)
        vec_ram[vec_idx] <= apb_req.pwdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  fetch_time_a: assert property (
    fetch_start |=> !vec_out.valid [*7] ##1 vec_out.valid)
    else $error("Vector not delivered eight cycles after acknowledge.");

  unused_src_a: assert property (
    pending[NUM_SRC-1:USED_SRC] == '0)
    else $error("Unused source became pending.");

  mask_off_a: assert property (
    (enable == '0) [*2] |=> cpu_group_irq_lines == 12'h000)
    else $error("Group line active with all sources disabled.");

  vec_store_a: assert property (
    vec_we |=> vec_ram[$past(vec_idx)] == $past(apb_req.pwdata))
    else $error("Vector table write lost.");

  line_fourteen_a: assert property (
    timer2_irq |=> cpu_irq_line_fourteen)
    else $error("Third timer did not reach line fourteen.");

  line_thirteen_a: assert property (
    (timer1_irq && ctrl[CTRL_T1_ROUTE]) |=> cpu_irq_line_thirteen)
    else $error("Routed second timer did not reach line thirteen.");

  timer0_group_a: assert property (
    (timer0_irq && !src_q[SRC_TIMER0]) |=> pending[SRC_TIMER0])
    else $error("First timer not captured as grouped source.");

  low_line_a: assert property (
    fetch_start |=> ($past(grp_act) & ((12'h001 << fetch_line) - 12'h001)) == 12'h000)
    else $error("Fetch did not take the lowest active line.");

  group_line_a: assert property (
    (grp_act[0] && !grp_act[11]) |=> cpu_group_irq_lines[0] && !cpu_group_irq_lines[11])
    else $error("Group line does not follow its own group.");
endmodule

// File: iex_ext_chan.sv
// Purpose: One external interrupt input with edge select and time stamp.
// Assumes: Pin is synchronous to ref_clk.
// Notes:   The stamp counter exists only when HAS_CNT is set.
`timescale 1ns/1ns
module iex_ext_chan
  import iex_pkg::*;
#(
  parameter bit HAS_CNT = 1'b1
)(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             pin,
  input  wire logic             enable,
  input  wire logic             rising,
  output logic                  event_pulse,
  output logic [CNT_W-1:0]      stamp
);
  logic             pin_q;
  logic             next_event;
  logic [CNT_W-1:0] next_stamp;
  logic             valid;

  always_comb
  begin
    valid = enable & (rising ? (pin & ~pin_q) : (~pin & pin_q));
    next_event = valid;
    if (!HAS_CNT)
      next_stamp = '0;
    else if (valid)
      next_stamp = '0;
    else
      next_stamp = stamp + 16'h0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_q       <= 1'b0;
      event_pulse <= 1'b0;
      stamp       <= '0;
    end
    else
    begin
      pin_q       <= pin;
      event_pulse <= next_event;
      stamp       <= next_stamp;
    end
  end

  edge_event_a: assert property (@(posedge ref_clk) disable iff (reset)
    (enable && rising && pin && !pin_q) |=> event_pulse)
    else $error("Enabled rising edge gave no event.");

  stamp_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (HAS_CNT && valid) |=> (stamp == 16'h0000) ##1 ($past(valid) || stamp == 16'h0001))
    else $error("Stamp counter not cleared and restarted on edge.");
endmodule

// File: iex_pkg.sv
// Purpose: Shared constants and types for the interrupt expander.
// Assumes: APB word addressing on paddr[11:2], 100 MHz ref_clk.
// Notes:   Word indices times four give byte addresses.
package iex_pkg;
  localparam int NUM_SRC   = 96;
  localparam int GRP_SIZE  = 8;
  localparam int NUM_GRP   = 12;
  localparam int USED_SRC  = 45;
  localparam int NUM_EXT   = 4;
  localparam int CNT_W     = 16;
  localparam int FETCH_CYC = 8;

  localparam logic [9:0] W_CTRL   = 10'h000;
  localparam logic [9:0] W_EXTCFG = 10'h001;
  localparam logic [9:0] W_STAT   = 10'h002;
  localparam logic [9:0] W_EN0    = 10'h004;
  localparam logic [9:0] W_PEND0  = 10'h010;
  localparam logic [9:0] W_CNT0   = 10'h020;
  localparam logic [9:0] W_VEC0   = 10'h080;

  localparam int CTRL_T1_ROUTE = 0;
  localparam int EXT_EN_BIT    = 0;
  localparam int EXT_POL_BIT   = 1;
  localparam int EXT_STRIDE    = 2;
  localparam int EXT_FIRST     = 0;
  localparam int EXT_SECOND    = 1;
  localparam int EXT_THIRTEEN  = 2;
  localparam int EXT_NMI       = 3;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EXTCFG_RST = 32'h0000_0000;

  localparam int SRC_TIMER0 = 0;
  localparam int SRC_EXT1   = 3;
  localparam int SRC_EXT2   = 4;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } iex_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } iex_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  src;
    logic [31:0] vector;
  } iex_vec_t;
endpackage

// File: interrupt_expansion_ext_irq_tb_top.sv
// Purpose: Self-checking bench for the interrupt expander.
// Assumes: The bench is the APB master; a processor model answers fetches.
// Notes:   Inputs change after rising edges; ports are checked at falling edges or right after an APB access or fetch.
`timescale 1ns/1ns
module interrupt_expansion_ext_irq_tb_top
  import iex_pkg::*;
;
  logic         ref_clk, reset, t0, t1, t2, x1, x2, xs, ack, take, done, l13, l14, nmi, err;
  logic [3:0]   dly, top;
  logic [6:0]   gsrc;
  logic [7:0]   lat;
  logic [11:0]  lines;
  logic [31:0]  gvec, rd, s0, s1;
  logic [95:0]  pirq;
  iex_apb_req_t req;
  iex_apb_rsp_t rsp;
  iex_vec_t     vo;
  int           n_mismatch, compares, nn, nl;
  int           vsrc [4] = '{1, 2, 17, 95};

  iex_expander dut (.ref_clk(ref_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .periph_irq(pirq), .timer0_irq(t0), .timer1_irq(t1), .timer2_irq(t2),
    .ext_irq_first(x1), .ext_irq_second(x2), .shared_nmi_irq_pin(xs), .cpu_ack(ack),
    .cpu_group_irq_lines(lines), .cpu_irq_line_thirteen(l13), .cpu_irq_line_fourteen(l14),
    .cpu_nmi(nmi), .cpu_top_line(top), .vec_out(vo));
  iex_cpu_model cpu (.ref_clk(ref_clk), .take(take), .delay(dly), .lines(lines),
    .vec_in(vo), .cpu_ack(ack), .done(done), .got_src(gsrc), .got_vec(gvec), .lat(lat));

  function automatic logic [31:0] vv(input int k);
    return 32'h00a5_0000 | 32'(k);
  endfunction

  task stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 16);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    n_mismatch += int'(rsp.pready !== 1'b1);
    if (rsp.pready !== 1'b1)
      stop_test;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("read error", 32'h0, {31'h0, err});
  endtask

  task fetch(input logic [3:0] d, input int s);
    int n;
    @(posedge ref_clk);
    dly <= d;
    take <= 1'b1;
    @(posedge ref_clk);
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    n_mismatch += int'(n >= 200);
    if (n >= 200)
      stop_test;
    chk("fetch source", 32'(s), {25'h0, gsrc});
    chk("fetch vector", vv(s), gvec);
    chk("fetch cycles", FETCH_CYC, {24'h0, lat});
    take <= 1'b0;
  endtask

  task pin_pulse;
    nn = 0;
    nl = 0;
    for (int k = 0; k < 12; k++)
    begin
      @(posedge ref_clk);
      xs <= (k < 5);
      @(negedge ref_clk);
      nn += int'(nmi === 1'b1);
      nl += int'(l13 === 1'b1);
    end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    {reset, t0, t1, t2, x1, x2, xs, take} = 8'h80;
    {req, pirq, dly, n_mismatch, compares} = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("top line", 32'hf, {28'h0, top});
    rdc("ctrl", 12'h000, CTRL_RST);
    rdc("extcfg", 12'h004, EXTCFG_RST);
    rdc("enable 0", 12'h010, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    foreach (vsrc[j]) wr(12'h200 + 12'(4 * vsrc[j]), vv(vsrc[j]));
    rdc("vector 95", 12'h37c, vv(95));
    rdc("vector 0", 12'h200, 32'h0);
    $display("test registers done");
    wr(12'h010, 32'h06);
    wr(12'h018, 32'h02);
    pirq <= 96'h4_0000_0002_0206;
    repeat (4) @(negedge ref_clk);
    chk("group lines", 32'h005, {20'h0, lines});
    chk("top line", 32'h0, {28'h0, top});
    rdc("pending 1", 12'h044, 32'h02);
    rdc("pending 6", 12'h058, 32'h00);
    fetch(4'h0, 1);
    fetch(4'h3, 2);
    repeat (2) @(negedge ref_clk);
    chk("group lines", 32'h004, {20'h0, lines});
    chk("top line", 32'h2, {28'h0, top});
    fetch(4'h1, 17);
    wr(12'h044, 32'h02);
    rdc("pending 1", 12'h044, 32'h00);
    chk("group lines", 32'h000, {20'h0, lines});
    pirq <= '0;
    $display("test fetch done");
    t0 <= 1'b1;
    @(posedge ref_clk);
    t0 <= 1'b0;
    rdc("pending 0", 12'h040, 32'h01);
    wr(12'h040, 32'h01);
    t2 <= 1'b1;
    @(negedge ref_clk);
    chk("line 14", 32'h0, {31'h0, l14});
    @(negedge ref_clk);
    chk("line 14", 32'h1, {31'h0, l14});
    @(posedge ref_clk);
    t2 <= 1'b0;
    t1 <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("line 13 unrouted", 32'h0, {31'h0, l13});
    wr(12'h000, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk("line 13 routed", 32'h1, {31'h0, l13});
    wr(12'h000, 32'h0);
    t1 <= 1'b0;
    $display("test timers done");
    pin_pulse;
    chk("disabled pulses", 32'h0, 32'(nn + nl));
    wr(12'h004, 32'hf7);
    wr(12'h010, 32'h18);
    x1 <= 1'b1;
    rdc("pending 0", 12'h040, 32'h08);
    apb(1'b0, 12'h080, 32'h0);
    s0 = rd;
    chk("stamp cleared", 32'h1, {31'h0, s0 < 32'd32});
    x1 <= 1'b0;
    x2 <= 1'b1;
    apb(1'b0, 12'h080, 32'h0);
    s1 = rd;
    chk("stamp step", 32'h4, s1 - s0);
    x2 <= 1'b0;
    rdc("pending 0", 12'h040, 32'h18);
    chk("group lines", 32'h001, {20'h0, lines});
    rdc("status", 12'h008, 32'h001);
    pin_pulse;
    chk("nmi pulses", 32'h1, 32'(nn));
    chk("line 13 pulses", 32'h1, 32'(nl));
    $display("test external done");
    stop_test;
  end
endmodule
